// *** rtl/eod_control.sv ***
// Register file and control logic for electrode-off detection
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps

// Operation
// - Separate positive and negative side enables per channel
// - Internal excitation off, comparators still active
// - DC: one side up, other down
// - Swap bit exchanges pull-up and pull-down sides
// - Two-bit field sets excitation current level
// - Three-bit field sets comparator threshold level
// - Comparator results held in two status registers
// - Both status registers go into output stream
// - Sleep bit powers down all comparators
// - AC mode alternates source and sink periodically
// - Rate field selects 7.8 or 31.2 Hz
// - Selector 110/111 routes bias return to side
// - Threshold at bits 7:5, also bias detection
module eod_control #(
    parameter int NCH = 8,
    parameter int unsigned AC_SLOW_HALF = eod_pkg::AC_SLOW_HALF,
    parameter int unsigned AC_FAST_HALF = eod_pkg::AC_FAST_HALF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Conversion strobe from the converter logic
    input wire logic conv_done,
    // Raw comparator outputs from the analog side
    input wire logic [NCH-1:0] comp_p_async,
    input wire logic [NCH-1:0] comp_n_async,
    // Excitation controls per channel side
    output logic [NCH-1:0] pull_up_p,
    output logic [NCH-1:0] pull_down_p,
    output logic [NCH-1:0] pull_up_n,
    output logic [NCH-1:0] pull_down_n,
    // Analog settings
    output logic [1:0] excitation_current_level,
    output logic [2:0] detect_threshold_level,
    output logic detect_comparator_sleep,
    // Bias return routing per channel
    output logic [NCH-1:0] bias_return_to_p,
    output logic [NCH-1:0] bias_return_to_n,
    // Status words for the conversion output stream
    output logic [2*NCH-1:0] stream_status_word,
    output logic stream_status_valid
);

    // Software registers
    logic [eod_pkg::CTRL_W-1:0] electrode_detect_control_q;
    logic [NCH-1:0] detect_enable_positive_side_q;
    logic [NCH-1:0] detect_enable_negative_side_q;
    logic [NCH-1:0] excitation_polarity_swap_q;
    logic [eod_pkg::CFG4_W-1:0] fourth_config_register_q;
    logic [eod_pkg::SEL_W*NCH-1:0] channel_input_selector_q;
    // Comparator status, written by hardware only
    logic [NCH-1:0] detect_status_positive_q;
    logic [NCH-1:0] detect_status_negative_q;
    // APB answer registers
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    // Output registers
    logic [NCH-1:0] pull_up_p_q;
    logic [NCH-1:0] pull_down_p_q;
    logic [NCH-1:0] pull_up_n_q;
    logic [NCH-1:0] pull_down_n_q;
    logic [NCH-1:0] bias_p_q;
    logic [NCH-1:0] bias_n_q;
    logic [2*NCH-1:0] stream_word_q;
    logic stream_valid_q;
    // Synchronised comparator levels
    logic [NCH-1:0] comp_p_s;
    logic [NCH-1:0] comp_n_s;
    // AC excitation phase
    logic ac_phase;

    // Comparator levels cross from the analog side
    eod_sync #(.W(NCH)) u_sync_p (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(comp_p_async),
        .sync_out(comp_p_s)
    );
    eod_sync #(.W(NCH)) u_sync_n (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(comp_n_async),
        .sync_out(comp_n_s)
    );

    // Field decode of the control registers
    wire [1:0] rate_sel = electrode_detect_control_q[eod_pkg::RATE_LO +: eod_pkg::RATE_W];
    wire comp_sleep = fourth_config_register_q[eod_pkg::CFG4_SLEEP_BIT];
    wire exc_off = fourth_config_register_q[eod_pkg::CFG4_EXC_OFF_BIT];

    // Source and sink alternation for AC detection
    eod_ac_timer #(
        .SLOW_HALF(AC_SLOW_HALF),
        .FAST_HALF(AC_FAST_HALF)
    ) u_ac_timer (
        .core_clk(core_clk),
        .rst(rst),
        .rate_sel(rate_sel),
        .phase(ac_phase)
    );

    // APB decode
    wire setup_ph = psel & ~penable;
    wire access_done = psel & penable & pready_q;
    wire wr_en = access_done & pwrite & ~pslverr_q;
    wire [7:0] word_addr = {paddr[7:2], 2'h0};
    wire hit_ctrl = (word_addr == eod_pkg::ADDR_CTRL);
    wire hit_sensp = (word_addr == eod_pkg::ADDR_SENSP);
    wire hit_sensn = (word_addr == eod_pkg::ADDR_SENSN);
    wire hit_flip = (word_addr == eod_pkg::ADDR_FLIP);
    wire hit_cfg4 = (word_addr == eod_pkg::ADDR_CFG4);
    wire hit_sel = (word_addr == eod_pkg::ADDR_SEL);
    wire hit_statp = (word_addr == eod_pkg::ADDR_STATP);
    wire hit_statn = (word_addr == eod_pkg::ADDR_STATN);
    wire addr_hit = hit_ctrl | hit_sensp | hit_sensn | hit_flip | hit_cfg4 | hit_sel | hit_statp | hit_statn;

    // Read word, also the base that a masked write merges into
    wire [31:0] rd_word;

    // Byte-lane merge of write data
    wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [31:0] old_word = rd_word;
    wire [31:0] new_word = (old_word & ~wmask) | (pwdata & wmask);

    // Read selection; unused upper bits read as zero
    assign rd_word = hit_ctrl ? {24'h00_0000, electrode_detect_control_q} :
                     hit_sensp ? {{(32-NCH){1'b0}}, detect_enable_positive_side_q} :
                     hit_sensn ? {{(32-NCH){1'b0}}, detect_enable_negative_side_q} :
                     hit_flip ? {{(32-NCH){1'b0}}, excitation_polarity_swap_q} :
                     hit_cfg4 ? {24'h00_0000, fourth_config_register_q} :
                     hit_sel ? {{(32-eod_pkg::SEL_W*NCH){1'b0}}, channel_input_selector_q} :
                     hit_statp ? {{(32-NCH){1'b0}}, detect_status_positive_q} :
                     hit_statn ? {{(32-NCH){1'b0}}, detect_status_negative_q} :
                     32'h0000_0000;

    // APB answer: one access cycle, read data captured in setup
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= eod_pkg::RST_WORD;
        end else if (setup_ph) begin
            pready_q <= 1'b1;
            pslverr_q <= ~addr_hit;
            prdata_q <= pwrite ? eod_pkg::RST_WORD : rd_word;
        end else if (access_done) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
    end

    // Software writes; status registers ignore writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            electrode_detect_control_q <= eod_pkg::RST_WORD[eod_pkg::CTRL_W-1:0];
            detect_enable_positive_side_q <= eod_pkg::RST_WORD[NCH-1:0];
            detect_enable_negative_side_q <= eod_pkg::RST_WORD[NCH-1:0];
            excitation_polarity_swap_q <= eod_pkg::RST_WORD[NCH-1:0];
            fourth_config_register_q <= eod_pkg::RST_WORD[eod_pkg::CFG4_W-1:0];
            channel_input_selector_q <= eod_pkg::RST_WORD[eod_pkg::SEL_W*NCH-1:0];
        end else if (wr_en) begin
            if (hit_ctrl) begin
                electrode_detect_control_q <= new_word[eod_pkg::CTRL_W-1:0];
            end
            if (hit_sensp) begin
                detect_enable_positive_side_q <= new_word[NCH-1:0];
            end
            if (hit_sensn) begin
                detect_enable_negative_side_q <= new_word[NCH-1:0];
            end
            if (hit_flip) begin
                excitation_polarity_swap_q <= new_word[NCH-1:0];
            end
            if (hit_cfg4) begin
                fourth_config_register_q <= new_word[eod_pkg::CFG4_W-1:0];
            end
            if (hit_sel) begin
                channel_input_selector_q <= new_word[eod_pkg::SEL_W*NCH-1:0];
            end
        end
    end

    // Excitation steering: in DC the positive side is pulled up unless swapped,
    // in AC the same pattern flips every half period
    wire ac_mode = (rate_sel == eod_pkg::RATE_SLOW) | (rate_sel == eod_pkg::RATE_FAST);
    wire [NCH-1:0] p_up = ~excitation_polarity_swap_q ^ {NCH{ac_mode & ac_phase}};
    wire [NCH-1:0] drive_p = detect_enable_positive_side_q & {NCH{~exc_off}};
    wire [NCH-1:0] drive_n = detect_enable_negative_side_q & {NCH{~exc_off}};

    // Bias return routing decode, one selector field per channel
    logic [NCH-1:0] bias_p_d;
    logic [NCH-1:0] bias_n_d;
    for (genvar i = 0; i < NCH; i++) begin : g_route
        assign bias_p_d[i] = (channel_input_selector_q[i*eod_pkg::SEL_W +: eod_pkg::SEL_W] == eod_pkg::SEL_BIAS_P);
        assign bias_n_d[i] = (channel_input_selector_q[i*eod_pkg::SEL_W +: eod_pkg::SEL_W] == eod_pkg::SEL_BIAS_N);
    end

    // Excitation and routing outputs are registered to keep pins glitch free
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pull_up_p_q <= '0;
            pull_down_p_q <= '0;
            pull_up_n_q <= '0;
            pull_down_n_q <= '0;
            bias_p_q <= '0;
            bias_n_q <= '0;
        end else begin
            pull_up_p_q <= drive_p & p_up;
            pull_down_p_q <= drive_p & ~p_up;
            pull_up_n_q <= drive_n & ~p_up;
            pull_down_n_q <= drive_n & p_up;
            bias_p_q <= bias_p_d;
            bias_n_q <= bias_n_d;
        end
    end

    // Comparators asleep give no result, so zeros are captured
    wire [NCH-1:0] cap_p = comp_p_s & {NCH{~comp_sleep}};
    wire [NCH-1:0] cap_n = comp_n_s & {NCH{~comp_sleep}};

    // Status and stream word are taken together at each conversion, so a
    // sample and its status always belong to the same conversion
    always_ff @(posedge core_clk) begin
        if (rst) begin
            detect_status_positive_q <= '0;
            detect_status_negative_q <= '0;
            stream_word_q <= '0;
            stream_valid_q <= 1'b0;
        end else begin
            stream_valid_q <= conv_done;
            if (conv_done) begin
                detect_status_positive_q <= cap_p;
                detect_status_negative_q <= cap_n;
                stream_word_q <= {cap_p, cap_n};
            end
        end
    end

    // Outputs, all straight from registers
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign pull_up_p = pull_up_p_q;
    assign pull_down_p = pull_down_p_q;
    assign pull_up_n = pull_up_n_q;
    assign pull_down_n = pull_down_n_q;
    assign excitation_current_level = electrode_detect_control_q[eod_pkg::CUR_LO +: eod_pkg::CUR_W];
    assign detect_threshold_level = electrode_detect_control_q[eod_pkg::TH_LO +: eod_pkg::TH_W];
    assign detect_comparator_sleep = fourth_config_register_q[eod_pkg::CFG4_SLEEP_BIT];
    assign bias_return_to_p = bias_p_q;
    assign bias_return_to_n = bias_n_q;
    assign stream_status_word = stream_word_q;
    assign stream_status_valid = stream_valid_q;

    // Checks
    sequence s_ctrl_write;
        wr_en && hit_ctrl && (pstrb[0] == 1'b1);
    endsequence
    sequence s_conv;
        conv_done && !comp_sleep;
    endsequence

    AST_SIDE_ENABLE: assert property (@(posedge core_clk) disable iff (rst)
        ##1 (((pull_up_p_q | pull_down_p_q) & ~$past(detect_enable_positive_side_q)) == '0))
        else $error("positive side excited without its enable");
    AST_EXC_OFF: assert property (@(posedge core_clk) disable iff (rst)
        exc_off |=> ((pull_up_p_q | pull_down_p_q | pull_up_n_q | pull_down_n_q) == '0))
        else $error("excitation active while internal sources are off");
    AST_DC_OPPOSITE: assert property (@(posedge core_clk) disable iff (rst)
        (!ac_mode && !exc_off && detect_enable_positive_side_q[0] && detect_enable_negative_side_q[0])
        |=> (pull_up_p_q[0] != pull_up_n_q[0]) && (pull_down_p_q[0] == pull_up_n_q[0]))
        else $error("DC excitation does not pull the two sides apart");
    AST_SWAP: assert property (@(posedge core_clk) disable iff (rst)
        (!ac_mode && !exc_off && detect_enable_positive_side_q[0])
        |=> (pull_down_p_q[0] == $past(excitation_polarity_swap_q[0])))
        else $error("polarity swap did not move the pull-down to the positive side");
    AST_THRESH_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        s_ctrl_write |=> (detect_threshold_level == $past(pwdata[7:5])))
        else $error("threshold level not taken from bits 7 to 5");
    AST_CURRENT_WRITE: assert property (@(posedge core_clk) disable iff (rst)
        s_ctrl_write |=> (excitation_current_level == $past(pwdata[3:2])))
        else $error("current level not taken from its field");
    AST_STATUS_CAPTURE: assert property (@(posedge core_clk) disable iff (rst)
        s_conv |=> ((detect_status_positive_q == $past(comp_p_s)) && (detect_status_negative_q == $past(comp_n_s)))
        ##1 ($past(conv_done) || $stable(detect_status_positive_q)))
        else $error("status not captured once per conversion");
    AST_STREAM: assert property (@(posedge core_clk) disable iff (rst)
        conv_done |=> stream_status_valid &&
        (stream_status_word == {detect_status_positive_q, detect_status_negative_q}))
        else $error("stream status word missing or wrong");
    AST_SLEEP: assert property (@(posedge core_clk) disable iff (rst)
        (conv_done && comp_sleep) |=> (detect_status_positive_q == '0) && (detect_status_negative_q == '0))
        else $error("status captured while comparators asleep");
    AST_BIAS_ROUTE: assert property (@(posedge core_clk) disable iff (rst)
        ##1 (bias_return_to_n[0] == ($past(channel_input_selector_q[2:0]) == eod_pkg::SEL_BIAS_N)))
        else $error("bias return routing does not follow selector code");

endmodule

// *** rtl/eod_pkg.sv ***
// Constants shared by the electrode-off detection control block
package eod_pkg;

    // APB register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SENSP = 8'h04;
    localparam logic [7:0] ADDR_SENSN = 8'h08;
    localparam logic [7:0] ADDR_FLIP = 8'h0C;
    localparam logic [7:0] ADDR_CFG4 = 8'h10;
    localparam logic [7:0] ADDR_SEL = 8'h14;
    localparam logic [7:0] ADDR_STATP = 8'h18;
    localparam logic [7:0] ADDR_STATN = 8'h1C;

    // Detection control register fields
    localparam int CTRL_W = 8;
    localparam int TH_LO = 5;
    localparam int TH_W = 3;
    localparam int CUR_LO = 2;
    localparam int CUR_W = 2;
    localparam int RATE_LO = 0;
    localparam int RATE_W = 2;

    // Fourth configuration register fields
    localparam int CFG4_W = 8;
    localparam int CFG4_SLEEP_BIT = 1;
    localparam int CFG4_EXC_OFF_BIT = 4;

    // Excitation rate codes
    localparam logic [1:0] RATE_DC = 2'h0;
    localparam logic [1:0] RATE_SLOW = 2'h1;
    localparam logic [1:0] RATE_FAST = 2'h2;

    // Input selector codes that bring the bias return onto a channel
    localparam int SEL_W = 3;
    localparam logic [2:0] SEL_BIAS_P = 3'h6;
    localparam logic [2:0] SEL_BIAS_N = 3'h7;

    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;

    // Timing: clock rate and AC excitation frequencies in millihertz
    localparam longint CLK_HZ = 40000000;
    localparam longint AC_SLOW_MHZ = 7800;
    localparam longint AC_FAST_MHZ = 31200;
    localparam longint MHZ_PER_HZ = 1000;
    // Half period in cycles, rounded down
    localparam int unsigned AC_SLOW_HALF = int'((CLK_HZ * MHZ_PER_HZ) / (2 * AC_SLOW_MHZ));
    localparam int unsigned AC_FAST_HALF = int'((CLK_HZ * MHZ_PER_HZ) / (2 * AC_FAST_MHZ));

endpackage

// *** rtl/eod_sync.sv ***
// Two-flop synchroniser for a bus of independent comparator levels
`timescale 1ns/1ps
module eod_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);

    // First stage, read only by the second stage
    logic [W-1:0] meta_q;
    // Second stage, safe to use
    logic [W-1:0] sync_q;

    // Each bit is a separate level; bits may settle in different cycles
    always_ff @(posedge core_clk) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

    assign sync_out = sync_q;

endmodule

// *** rtl/eod_ac_timer.sv ***
// Phase generator for the alternating source and sink excitation
`timescale 1ns/1ps
module eod_ac_timer #(
    parameter int unsigned SLOW_HALF = eod_pkg::AC_SLOW_HALF,
    parameter int unsigned FAST_HALF = eod_pkg::AC_FAST_HALF
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Rate choice
    input wire logic [1:0] rate_sel,
    // Excitation phase, high means sink on the normally pulled-up side
    output logic phase
);

    // Half-period counter
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    // Current phase
    logic phase_q;
    logic phase_d;

    // Decode of rate and terminal count
    wire is_slow = (rate_sel == eod_pkg::RATE_SLOW);
    wire is_fast = (rate_sel == eod_pkg::RATE_FAST);
    wire ac_on = is_slow | is_fast;
    wire [31:0] limit = is_slow ? (SLOW_HALF - 32'h0000_0001) : (FAST_HALF - 32'h0000_0001);
    // Compare with >= so a switch to the faster rate never overruns
    wire at_end = (cnt_q >= limit);

    assign cnt_d = (!ac_on || at_end) ? 32'h0000_0000 : cnt_q + 32'h0000_0001;
    assign phase_d = ac_on ? (phase_q ^ at_end) : 1'b0;

    // Counter and phase registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cnt_q <= 32'h0000_0000;
            phase_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            phase_q <= phase_d;
        end
    end

    assign phase = phase_q;

    // While AC is on, phase only flips at the terminal count of the chosen rate
    AST_AC_HOLD: assert property (@(posedge core_clk) disable iff (rst)
        (ac_on && !at_end) |=> ($stable(phase_q) || !ac_on))
        else $error("excitation phase flipped before half period ended");
    AST_AC_FLIP: assert property (@(posedge core_clk) disable iff (rst)
        (ac_on && at_end) ##1 ac_on |-> (phase_q != $past(phase_q)))
        else $error("excitation phase did not flip at half period");

endmodule

// *** dv/eod_host.sv ***
// Host controller model that reaches the detection registers over APB
`timescale 1ns/1ps
module eod_host (
    // Clock
    input wire logic core_clk,
    // APB request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    output logic [3:0] pstrb,
    // APB answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
    end

    // One transfer; status is only known from a read, never from output codes
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                        output logic [31:0] rdata, output logic err, output logic ok);
        int n;
        ok = 1'b0;
        err = 1'b0;
        rdata = 32'h0000_0000;
        @(posedge core_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        pstrb <= 4'hF;
        @(posedge core_clk);
        penable <= 1'b1;
        // Bounded wait for the answer; a lost pready is reported by the caller
        for (n = 0; n < 16 && !ok; n++) begin
            @(posedge core_clk);
            if (pready === 1'b1) begin
                ok = 1'b1;
                rdata = prdata;
                err = pslverr;
            end
        end
        // Released lines stop showing the last value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~addr;
        pwdata <= ~wdata;
    endtask
endmodule

// *** dv/testbench.sv ***
// Self-checking bench for the electrode-off detection control block
`timescale 1ns/1ps
module testbench;
    // Shortened AC half periods keep the run short
    localparam int SLOW = 40;
    localparam int FAST = 10;
    // One register access and its expected answer
    typedef struct {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic [31:0] exp_rd;
        logic exp_err;
    } eod_row_s;
    eod_row_s rows [8] = '{
        '{eod_pkg::ADDR_CTRL, 32'h0000_00A4, 32'h0000_00A4, 1'b0},
        '{eod_pkg::ADDR_SENSP, 32'h0000_005A, 32'h0000_005A, 1'b0},
        '{eod_pkg::ADDR_SENSN, 32'h0000_00A5, 32'h0000_00A5, 1'b0},
        '{eod_pkg::ADDR_FLIP, 32'h0000_000F, 32'h0000_000F, 1'b0},
        '{eod_pkg::ADDR_CFG4, 32'h0000_0002, 32'h0000_0002, 1'b0},
        '{eod_pkg::ADDR_SEL, 32'h00E0_0006, 32'h00E0_0006, 1'b0},
        '{eod_pkg::ADDR_STATP, 32'h0000_00FF, 32'h0000_0000, 1'b0},
        '{8'h20, 32'h0000_00FF, 32'h0000_0000, 1'b1}};
    // Clock, reset and design wires
    logic core_clk = 1'b0, rst = 1'b1, conv_done = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, sleep, valid;
    logic [7:0] paddr, comp_p = 8'h00, comp_n = 8'h00, up_p, dn_p, up_n, dn_n, bias_p, bias_n;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [1:0] cur;
    logic [2:0] thr;
    logic [15:0] word;
    logic err;
    int num_errors = 0, n_checks = 0;

    always #12.5 core_clk = ~core_clk;

    eod_host u_host (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    eod_control #(.NCH(8), .AC_SLOW_HALF(SLOW), .AC_FAST_HALF(FAST)) u_dut (.core_clk(core_clk), .rst(rst),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .comp_p_async(comp_p),
        .comp_n_async(comp_n), .pull_up_p(up_p), .pull_down_p(dn_p), .pull_up_n(up_n), .pull_down_n(dn_n),
        .excitation_current_level(cur), .detect_threshold_level(thr), .detect_comparator_sleep(sleep),
        .bias_return_to_p(bias_p), .bias_return_to_n(bias_n), .stream_status_word(word),
        .stream_status_valid(valid));

    // Verdict and end of run
    task automatic print_verdict();
        if (num_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compare and count
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One bus access; a missing pready counts as a mismatch
    task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
        logic ok;
        u_host.xfer(wr, addr, wdata, rd, err, ok);
        check("pready", 32'h1, 32'(ok));
        // A lost answer ends the run at once
        if (ok !== 1'b1) begin
            print_verdict();
        end
    endtask

    // Let register changes and synchronisers settle
    task automatic settle();
        repeat (4) @(posedge core_clk);
        #1;
    endtask

    // One conversion result, then look at the stream in its single valid cycle
    task automatic convert(input logic [15:0] exp);
        @(posedge core_clk);
        conv_done <= 1'b1;
        @(posedge core_clk);
        conv_done <= 1'b0;
        #1;
        check("stream_valid", 32'h1, 32'(valid));
        check("stream_word", 32'(exp), 32'(word));
    endtask

    // Edges between two swaps of the excitation, skipping the first partial half
    task automatic half_period(input int exp);
        int n, k;
        logic last;
        for (k = 0; k < 3; k++) begin
            last = up_p[4];
            n = 0;
            while (up_p[4] === last && n < 1000) begin
                @(posedge core_clk);
                #1;
                n++;
            end
        end
        check("ac_half", 32'(exp), 32'(n));
        // A phase that never flips ends the run at once
        if (n >= 1000) begin
            print_verdict();
        end
    endtask

    // Watchdog so that no hang outlives the run limit
    initial begin
        repeat (100000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        // Table of writes and read-backs, unmapped and read-only places included
        foreach (rows[i]) begin
            access(1'b1, rows[i].addr, rows[i].wdata);
            check("write_err", 32'(rows[i].exp_err), 32'(err));
            access(1'b0, rows[i].addr, 32'h0000_0000);
            check("read_data", rows[i].exp_rd, rd);
        end
        settle();
        check("current", 32'h1, 32'(cur));
        check("threshold", 32'h5, 32'(thr));
        check("sleep", 32'h1, 32'(sleep));
        check("bias_p", 32'h01, 32'(bias_p));
        check("bias_n", 32'h80, 32'(bias_n));
        check("up_p", 32'h50, 32'(up_p));
        check("down_p", 32'h0A, 32'(dn_p));
        check("up_n", 32'h05, 32'(up_n));
        check("down_n", 32'hA0, 32'(dn_n));
        // Sleeping comparators report nothing
        comp_p <= 8'h3C;
        comp_n <= 8'hC3;
        settle();
        convert(16'h0000);
        // Excitation off, comparators still sensing
        access(1'b1, eod_pkg::ADDR_CFG4, 32'h0000_0010);
        settle();
        check("pulls_off", 32'h0, 32'({up_p, dn_p, up_n, dn_n}));
        convert(16'h3CC3);
        access(1'b0, eod_pkg::ADDR_STATP, 32'h0000_0000);
        check("status_p", 32'h3C, rd);
        access(1'b0, eod_pkg::ADDR_STATN, 32'h0000_0000);
        check("status_n", 32'hC3, rd);
        // Status holds between conversions
        comp_p <= 8'h81;
        comp_n <= 8'h18;
        settle();
        check("held_word", 32'h3CC3, 32'(word));
        check("no_valid", 32'h0, 32'(valid));
        convert(16'h8118);
        // Both AC rates, measured on a pulled-up positive side
        access(1'b1, eod_pkg::ADDR_CFG4, 32'h0000_0000);
        access(1'b1, eod_pkg::ADDR_CTRL, 32'h0000_00A5);
        half_period(SLOW);
        access(1'b1, eod_pkg::ADDR_CTRL, 32'h0000_00A6);
        half_period(FAST);
        // Reset in mid-run clears settings and outputs
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        #1;
        check("rst_out", 32'h0, 32'({up_p, dn_p, up_n, dn_n}));
        check("rst_misc", 32'h0, 32'({word, valid, sleep, thr, cur, bias_p}));
        access(1'b0, eod_pkg::ADDR_SEL, 32'h0000_0000);
        check("rst_sel", 32'h0, rd);
        print_verdict();
    end
endmodule
